// ==== design/i2c_single_master_receive_seq.sv ====
// Single-master two-wire sequencer for plain and write-then-read reads.
// Summary of operation
// RULE_01 - Read: start, address, direction bit one.
// RULE_02 - Acknowledge every received byte except last.
// RULE_03 - Last byte not acknowledged, then stop.
// RULE_04 - Combined: start, address with write, data.
// RULE_05 - Repeated start, address with read, receive.
// RULE_06 - Completion signalled only after the stop.
// RULE_07 - Controller uninitialized, idle or communicating.
// RULE_08 - Target flag holds idle, done, nack, error.
// RULE_09 - One flag per target, one transfer active.
// RULE_10 - Launch enables data-empty and end interrupts.
// RULE_11 - Channel n end maps to group bit 2n.
// RULE_12 - Bit rate never above 384 kbps.
// RULE_13 - Interrupt after start, address, byte, stop.
// RULE_14 - Address nack: stop, flag not acknowledged.
// RULE_15 - Bus conflict: error flag, halt until reset.
module i2c_single_master_receive_seq
  #(
  // RULE_12 bit rate limit
  parameter int QUARTER = i2c_seq_pkg::QUARTER_CYCLES,
  parameter int NT = i2c_seq_pkg::NUM_TARGETS,
  parameter int CHANNEL = i2c_seq_pkg::CHANNEL_NUM,
  parameter int GROUP_W = i2c_seq_pkg::GROUP_WIDTH,
  parameter int DEPTH = i2c_seq_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host control
  input wire logic init,
  input wire logic chan_reset,
  input wire logic cmd_valid,
  input wire logic cmd_mode,
  input wire logic [$clog2(NT)-1:0] cmd_target,
  input wire logic [i2c_seq_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [7:0] cmd_wr_count,
  input wire logic [7:0] cmd_rd_count,
  // Bytes to write
  input wire logic [i2c_seq_pkg::BYTE_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // Received bytes
  output logic [i2c_seq_pkg::BYTE_W-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  // Status and interrupts
  output i2c_seq_pkg::ctl_type ctl_state,
  output i2c_seq_pkg::flag_type target_flags [NT],
  output logic tx_data_empty_irq,
  output logic tx_end_irq,
  output logic [GROUP_W-1:0] shared_group_irq,
  // Bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  import i2c_seq_pkg::*;

  localparam int TW = $clog2(NT);
  localparam int GRP_BIT = 2 * CHANNEL;
  localparam int QW = $clog2(QUARTER + 1);
  localparam logic [QW-1:0] QRELOAD = QW'(QUARTER - 1);

  seq_type seq;
  logic [1:0] phase;
  logic [QW-1:0] qcnt;
  logic [3:0] bit_idx;
  logic [7:0] sr;
  logic reading;
  logic mode;
  logic nacked;
  logic irq_en;
  logic push;
  logic [TW-1:0] cur_target;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wr_left;
  logic [7:0] rd_left;
  logic scl_m;
  logic scl_s;
  logic sda_m;
  logic sda_s;
  logic next_scl_oe;
  logic next_sda_oe;
  logic launch;
  logic stall;
  logic step;
  logic unit_end;
  logic byte_end;
  logic start_end;
  logic stop_end;
  logic bus_err;
  logic restart;
  logic bit_val;
  logic wr_done;

  stream_if #(.W(BYTE_W)) wr_if ();
  stream_if #(.W(BYTE_W)) rd_if ();

  rx_fifo #(.W(BYTE_W), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .wr(wr_if.sink),
    .rd(rd_if.source)
  );

  assign wr_if.valid = push;
  assign wr_if.data = sr;
  assign rd_if.ready = rx_ready;
  assign rx_data = rd_if.data;
  assign rx_valid = rd_if.valid;
  // Open-drain: only the enables move, the driven level is always low.
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  // ===========================================================
  // Bit timing
  // RULE_09 one transfer at a time
  assign launch = cmd_valid && ctl_state == ctl_idle;
  // The next byte waits with the clock held low, so the buffer never
  // overflows and a slow host simply slows the bus.
  assign stall = tx_ready || (seq == sq_read && bit_idx == BIT_FIRST &&
                 phase == 2'd0 && !wr_if.ready);
  assign step = seq != sq_idle && seq != sq_halt && qcnt == '0 &&
                !stall && !(phase == 2'd2 && !scl_s);
  assign unit_end = step && phase == 2'd3;
  assign byte_end = unit_end && bit_idx == 4'h0 &&
                    seq inside {sq_addr, sq_write, sq_read};
  assign start_end = unit_end && seq == sq_start;
  assign stop_end = unit_end && seq == sq_stop;
  // RULE_15 released bit seen low
  assign bus_err = unit_end && seq inside {sq_addr, sq_write} &&
                   bit_idx != 4'h0 && sr[7] && !sda_s;
  assign restart = reading && mode == MODE_WRITE_READ;
  assign wr_done = (seq == sq_write) ? (wr_left == COUNT_LAST)
                                     : (wr_left == 8'h00);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      sda_m <= sda_in;
      sda_s <= sda_m;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      qcnt <= QRELOAD;
      phase <= 2'd0;
    end else if (seq == sq_idle || seq == sq_halt) begin
      qcnt <= QRELOAD;
      phase <= 2'd0;
    end else if (step) begin
      qcnt <= QRELOAD;
      phase <= phase + 2'd1;
    end else if (qcnt != '0) begin
      qcnt <= qcnt - 1'b1;
    end
  end

  // ===========================================================
  // Transfer sequence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq <= sq_idle;
      sr <= '0;
      bit_idx <= BIT_FIRST;
      reading <= 1'b0;
      mode <= MODE_READ;
      nacked <= 1'b0;
      addr <= '0;
      wr_left <= '0;
      rd_left <= '0;
      cur_target <= '0;
      tx_ready <= 1'b0;
      push <= 1'b0;
    end else if (chan_reset) begin
      seq <= sq_idle;
      tx_ready <= 1'b0;
      push <= 1'b0;
    end else if (launch) begin
      seq <= sq_start;
      mode <= cmd_mode;
      // RULE_01 direction of plain read
      reading <= (cmd_mode == MODE_READ);
      addr <= cmd_addr;
      wr_left <= cmd_wr_count;
      rd_left <= cmd_rd_count;
      cur_target <= cmd_target;
      nacked <= 1'b0;
    end else begin
      push <= byte_end && seq == sq_read;
      if (tx_ready && tx_valid) begin
        sr <= tx_data;
        tx_ready <= 1'b0;
      end
      if (bus_err) begin
        seq <= sq_halt;
      end else if (unit_end) begin
        unique case (seq)
          sq_start: begin
            // RULE_04 address with direction bit
            sr <= {addr, reading ? DIR_READ : DIR_WRITE};
            bit_idx <= BIT_FIRST;
            seq <= sq_addr;
          end
          sq_stop: seq <= sq_idle;
          sq_addr, sq_write, sq_read: begin
            if (bit_idx != 4'h0) begin
              bit_idx <= bit_idx - 4'h1;
              sr <= {sr[6:0], (seq == sq_read) ? sda_s : 1'b0};
            end else begin
              bit_idx <= BIT_FIRST;
              if (seq == sq_write) begin
                wr_left <= wr_left - 8'h01;
              end
              // RULE_14 nack abandons transfer
              if (seq != sq_read && sda_s) begin
                nacked <= 1'b1;
                seq <= sq_stop;
              end else if (seq == sq_read) begin
                rd_left <= rd_left - 8'h01;
                // RULE_03 stop after last byte
                if (rd_left == COUNT_LAST) begin
                  seq <= sq_stop;
                end
              end else if (seq == sq_addr && reading) begin
                seq <= sq_read;
              end else if (wr_done) begin
                // RULE_05 repeated start, no stop
                seq <= sq_start;
                reading <= 1'b1;
              end else begin
                seq <= sq_write;
                tx_ready <= 1'b1;
              end
            end
          end
          sq_idle, sq_halt: seq <= seq;
        endcase
      end
    end
  end

  // ===========================================================
  // Pin drive
  always_comb begin
    bit_val = (bit_idx == 4'h0) ? 1'b0 : !sr[7];
    if (seq == sq_read) begin
      // RULE_02 acknowledge unless last
      bit_val = (bit_idx == 4'h0) ? (rd_left != COUNT_LAST) : 1'b0;
    end
    next_scl_oe = 1'b0;
    next_sda_oe = 1'b0;
    unique case (seq)
      sq_start: begin
        next_scl_oe = (phase == 2'd0) ? restart
                    : (phase == 2'd1) ? scl_oe : 1'b0;
        next_sda_oe = (phase == 2'd3) ? 1'b1
                    : (phase == 2'd0) ? sda_oe : 1'b0;
      end
      sq_addr, sq_write, sq_read: begin
        next_scl_oe = (phase < 2'd2);
        next_sda_oe = (phase == 2'd0) ? sda_oe : bit_val;
      end
      sq_stop: begin
        next_scl_oe = (phase < 2'd2);
        next_sda_oe = (phase == 2'd3) ? 1'b0
                    : (phase == 2'd0) ? sda_oe : 1'b1;
      end
      sq_idle, sq_halt: begin
        next_scl_oe = 1'b0;
        next_sda_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
    end
  end

  // ===========================================================
  // Controller state and target flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_state <= ctl_uninit;
    end else if (chan_reset) begin
      ctl_state <= ctl_uninit;
    end else if (init && ctl_state == ctl_uninit) begin
      ctl_state <= ctl_idle;
    end else if (launch) begin
      // RULE_07 communicating while busy
      ctl_state <= ctl_comm;
    end else if (stop_end) begin
      ctl_state <= ctl_idle;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NT; i++) begin
        target_flags[i] <= flag_no_init;
      end
    end else if (chan_reset || (init && ctl_state == ctl_uninit)) begin
      for (int i = 0; i < NT; i++) begin
        target_flags[i] <= chan_reset ? flag_no_init : flag_idle;
      end
    end else if (launch) begin
      // RULE_09 flag of this target only
      target_flags[cmd_target] <= flag_comm;
    end else if (bus_err) begin
      target_flags[cur_target] <= flag_error;
    end else if (stop_end) begin
      // RULE_08 idle with outcome
      target_flags[cur_target] <= nacked ? state_not_acknowledged
                                         : state_transfer_done;
    end
  end

  // ===========================================================
  // Interrupts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en <= 1'b0;
      tx_data_empty_irq <= 1'b0;
      tx_end_irq <= 1'b0;
      shared_group_irq <= '0;
    end else begin
      // RULE_10 enabled on launch
      if (chan_reset || stop_end) begin
        irq_en <= 1'b0;
      end else if (launch) begin
        irq_en <= 1'b1;
      end
      // RULE_13 progress interrupts
      tx_data_empty_irq <= irq_en && !chan_reset && (start_end || byte_end);
      // RULE_06 end only after stop
      tx_end_irq <= irq_en && !chan_reset && stop_end;
      // RULE_11 group bit 2n
      shared_group_irq <= '0;
      shared_group_irq[GRP_BIT] <= irq_en && !chan_reset && stop_end;
    end
  end

  // ===========================================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_READ_DIR: assert property ( // RULE_01
    (seq == sq_addr && bit_idx == 4'h1 && phase == 2'd2 && reading)
    |-> !sda_oe) else $error("read address lacks direction one");
  AST_WRITE_DIR: assert property ( // RULE_04
    (seq == sq_addr && bit_idx == 4'h1 && phase == 2'd2 && !reading)
    |-> sda_oe) else $error("write address lacks direction zero");
  AST_ACK_BYTE: assert property ( // RULE_02
    (seq == sq_read && bit_idx == 4'h0 && phase == 2'd2 &&
     rd_left != COUNT_LAST) |-> sda_oe) else $error("missing ack");
  AST_NACK_LAST: assert property ( // RULE_03
    (byte_end && seq == sq_read && rd_left == COUNT_LAST)
    |-> !sda_oe ##1 seq == sq_stop) else $error("last byte not nacked");
  AST_RESTART: assert property ( // RULE_05
    start_end |=> seq == sq_addr && sr == {addr, reading})
    else $error("address not sent after start");
  AST_END_AFTER_STOP: assert property ( // RULE_06
    tx_end_irq |-> seq == sq_idle && $past(seq) == sq_stop)
    else $error("end signalled before stop");
  AST_CTL_COMM: assert property ( // RULE_07
    seq != sq_idle |-> ctl_state == ctl_comm)
    else $error("busy while not communicating");
  AST_FLAG_COMM: assert property ( // RULE_09
    (launch && !chan_reset) |=>
    target_flags[cur_target] == flag_comm && irq_en)
    else $error("launch did not mark target");
  AST_GROUP_BIT: assert property ( // RULE_11
    shared_group_irq[GRP_BIT] == tx_end_irq)
    else $error("group bit differs from end interrupt");
  AST_PROGRESS: assert property ( // RULE_13
    (start_end && irq_en) |=> tx_data_empty_irq)
    else $error("no interrupt after start");
  AST_NACK_FLAG: assert property ( // RULE_14
    (stop_end && nacked) |=>
    target_flags[cur_target] == state_not_acknowledged)
    else $error("nack not recorded");
  AST_HALT: assert property ( // RULE_15
    (bus_err && !chan_reset) |=> seq == sq_halt ##1 seq == sq_halt)
    else $error("sequencing continued after error");

  COV_READ_DONE: cover property (stop_end && !nacked && mode == MODE_READ);
  COV_COMBINED: cover property (start_end && restart);
  COV_NACK: cover property (stop_end && nacked);
  COV_STALL: cover property (stall && !tx_ready);

endmodule

// ==== design/i2c_seq_pkg.sv ====
// Shared constants and types for the two-wire receive sequencer.
package i2c_seq_pkg;

  // ===========================================================
  // Timing
  localparam int CLK_KHZ = 25000;
  localparam int BIT_RATE_KBPS = 384;
  localparam int QUARTERS_PER_BIT = 4;
  // The bus never runs faster than the top rate, so a quarter rounds up.
  localparam int QUARTER_CYCLES =
    (CLK_KHZ + QUARTERS_PER_BIT * BIT_RATE_KBPS - 1) /
    (QUARTERS_PER_BIT * BIT_RATE_KBPS);

  // ===========================================================
  // Sizes
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 7;
  localparam int FIFO_DEPTH = 32;
  localparam int NUM_TARGETS = 4;
  localparam int GROUP_WIDTH = 32;
  localparam int CHANNEL_NUM = 0;
  localparam logic [3:0] BIT_FIRST = 4'h8;
  localparam logic [7:0] COUNT_LAST = 8'h01;

  // ===========================================================
  // Encodings
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  localparam logic MODE_READ = 1'b0;
  localparam logic MODE_WRITE_READ = 1'b1;

  typedef enum logic [1:0] {ctl_uninit, ctl_idle, ctl_comm} ctl_type;

  typedef enum logic [2:0] {
    flag_no_init,
    flag_idle,
    state_transfer_done,
    state_not_acknowledged,
    flag_comm,
    flag_error
  } flag_type;

  typedef enum logic [2:0] {
    sq_idle, sq_start, sq_addr, sq_write, sq_read, sq_stop, sq_halt
  } seq_type;

endpackage

// ==== design/stream_if.sv ====
// Valid/ready byte stream between the sequencer and its receive buffer.
interface stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport source (output data, output valid, input ready);
  modport sink (input data, input valid, output ready);
endinterface

// ==== design/rx_fifo.sv ====
// Receive buffer with a registered output stage.
module rx_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Streams
  stream_if.sink wr,
  stream_if.source rd
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic push;
  logic pop;

  // Pointers wrap naturally, so DEPTH must be a power of two.
  assign wr.ready = (cnt != FULL);
  assign push = wr.valid && wr.ready;
  assign pop = (cnt != '0) && (!rd.valid || rd.ready);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= wr.data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (pop) begin
        rp <= rp + 1'b1;
      end
      if (push && !pop) begin
        cnt <= cnt + 1'b1;
      end else if (pop && !push) begin
        cnt <= cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd.valid <= 1'b0;
      rd.data <= '0;
    end else if (pop) begin
      rd.valid <= 1'b1;
      rd.data <= mem[rp];
    end else if (rd.ready) begin
      rd.valid <= 1'b0;
    end
  end

endmodule

// ==== tb/i2c_slave_model.sv ====
// Behavioural slave on the two-wire bus, able to stretch the clock.
module i2c_slave_model #(
  parameter logic [6:0] ADDR = 7'h5a
) (
  // Clock
  input wire logic clk,
  // Wire levels and stretch request
  input wire logic scl,
  input wire logic sda,
  input wire logic stretch_en,
  // Pull-downs
  output logic scl_low,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Bus tracking
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic mack = 1'b0;
  logic acked = 1'b0;
  logic [7:0] sh = 8'h00;
  logic [7:0] txb = 8'h00;
  int phase = 0;
  int cnt = 0;
  int idx = 0;
  int stretch = 0;
  int restarts = 0;
  int stops = 0;
  int sent = 0;
  logic [7:0] wlog [$];
  logic mlog [$];

  // Released lines float to the pull-up level through the wire AND.
  assign scl_low = (stretch != 0);
  initial sda_low = 1'b0;

  always @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (stretch != 0) stretch <= stretch - 1;
    if (scl && scl_q && sda_q && !sda) begin
      restarts += int'(phase != 0);
      phase = 1;
      cnt = 0;
      sda_low <= 1'b0;
    end else if (scl && scl_q && !sda_q && sda) begin
      stops++;
      phase = 0;
      sda_low <= 1'b0;
    end else if (scl && !scl_q && phase != 0) begin
      if (phase < 3 && cnt < 8) sh = {sh[6:0], sda};
      if (phase == 3 && cnt == 8) begin
        mack = !sda;
        mlog.push_back(sda);
      end
      cnt++;
    end else if (!scl && scl_q && phase != 0) begin
      if (stretch_en) stretch <= 6;
      if (phase == 3 && cnt < 8) begin
        sda_low <= ~txb[7-cnt];
      end else if (cnt == 8) begin
        acked = (phase == 2) || (sh[7:1] == ADDR);
        sda_low <= (phase != 3) && acked;
        if (phase != 3) wlog.push_back(sh);
      end else if (cnt == 9) begin
        cnt = 0;
        sda_low <= 1'b0;
        if (phase == 3) begin
          acked = mack;
          sent += int'(mack);
          idx++;
        end else begin
          idx = 0;
        end
        if (!acked) begin
          phase = 0;
        end else if (phase == 3 || (phase == 1 && sh[0])) begin
          phase = 3;
          txb = 8'hc3 ^ 8'(idx);
          sda_low <= ~txb[7];
        end else begin
          phase = 2;
        end
      end
    end
  end
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the receive sequencer against a slave model.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import i2c_seq_pkg::*;
  localparam logic [6:0] SLV = 7'h5a;
  logic clk = 0, rst_n = 0, init = 0, chan_reset = 0;
  logic cmd_valid = 0, cmd_mode = 0, tx_valid = 0, rx_ready = 0;
  logic [1:0] cmd_target = 0;
  logic [6:0] cmd_addr = 0;
  logic [7:0] cmd_wr_count = 0, cmd_rd_count = 0, tx_data = 0, rx_data;
  logic tx_ready, rx_valid, txe_irq, end_irq, scl_oe, sda_oe;
  logic scl_low, sda_low, jam = 0, stretch_en = 0, sink_en = 0, taken = 0;
  logic [31:0] grp;
  ctl_type ctl_state;
  flag_type flags [4];
  int err_total = 0, samples_checked = 0, cycles = 0, n_txe = 0, ph = 0;
  logic [7:0] wq [$];
  logic [7:0] rxq [$];
  wire logic scl_w = ~scl_oe & ~scl_low;
  wire logic sda_w = ~sda_oe & ~sda_low & ~jam;

  always #20 clk = ~clk;

  i2c_single_master_receive_seq #(.QUARTER(2))
    i2c_single_master_receive_seq_i (
    .clk(clk), .rst_n(rst_n), .init(init), .chan_reset(chan_reset),
    .cmd_valid(cmd_valid), .cmd_mode(cmd_mode), .cmd_target(cmd_target),
    .cmd_addr(cmd_addr), .cmd_wr_count(cmd_wr_count),
    .cmd_rd_count(cmd_rd_count), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .ctl_state(ctl_state), .target_flags(flags),
    .tx_data_empty_irq(txe_irq), .tx_end_irq(end_irq),
    .shared_group_irq(grp), .scl_in(scl_w), .scl_out(), .scl_oe(scl_oe),
    .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe));

  i2c_slave_model #(.ADDR(SLV)) i2c_slave_model_i (
    .clk(clk), .scl(scl_w), .sda(sda_w), .stretch_en(stretch_en),
    .scl_low(scl_low), .sda_low(sda_low));

  // ==========================================================
  // Checking and closing
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task close_out;
    if (err_total == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================
  // Host side: receive sink with stalls, write byte source
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      close_out();
    end
    n_txe += int'(txe_irq === 1'b1);
    if (rx_valid && rx_ready) rxq.push_back(rx_data);
    if (tx_valid && tx_ready) taken = 1'b1;
    if (rst_n) chk("group", 32'(end_irq) << (2 * CHANNEL_NUM), grp);
  end

  always @(negedge clk) begin
    ph++;
    rx_ready <= sink_en && (ph % 3 != 0);
    if (taken) begin
      taken = 1'b0;
      tx_valid <= 1'b0;
      void'(wq.pop_front());
    end else if (!tx_valid && tx_ready && wq.size() > 0) begin
      tx_valid <= 1'b1;
      tx_data <= wq[0];
    end
  end

  task automatic launch(input logic m, input logic [1:0] t,
                        input logic [6:0] a, input logic [7:0] w, r);
    @(negedge clk);
    cmd_mode = m;
    cmd_target = t;
    cmd_addr = a;
    cmd_wr_count = w;
    cmd_rd_count = r;
    cmd_valid = 1;
    @(negedge clk);
    cmd_valid = 0;
  endtask

  task automatic wait_end(input int lim);
    int k;
    k = 0;
    while (end_irq !== 1'b1 && k < lim) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("end pulse", 32'h1, 32'(end_irq));
    chk("scl oe", 32'h0, 32'(scl_oe));
    chk("sda oe", 32'h0, 32'(sda_oe));
    repeat (12) @(posedge clk);
    @(negedge clk);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    chk("ctl", 32'(ctl_uninit), 32'(ctl_state));
    for (int i = 0; i < 4; i++) chk("flag", 32'(flag_no_init), 32'(flags[i]));
    init = 1;
    @(negedge clk);
    init = 0;
    @(negedge clk);
    chk("ctl", 32'(ctl_idle), 32'(ctl_state));
    for (int i = 0; i < 4; i++) chk("flag", 32'(flag_idle), 32'(flags[i]));
  endtask

  task automatic t_read;
    int s0, t0;
    s0 = i2c_slave_model_i.stops;
    t0 = n_txe;
    i2c_slave_model_i.wlog.delete();
    i2c_slave_model_i.mlog.delete();
    rxq.delete();
    sink_en = 1;
    launch(1'b0, 2'd1, SLV, 8'h00, 8'h03);
    chk("ctl", 32'(ctl_comm), 32'(ctl_state));
    chk("flag1", 32'(flag_comm), 32'(flags[1]));
    launch(1'b0, 2'd2, SLV, 8'h00, 8'h01);
    chk("busy flag2", 32'(flag_idle), 32'(flags[2]));
    wait_end(2000);
    chk("stops", 32'(s0 + 1), 32'(i2c_slave_model_i.stops));
    chk("flag1", 32'(state_transfer_done), 32'(flags[1]));
    chk("ctl", 32'(ctl_idle), 32'(ctl_state));
    chk("addr", {25'h0, SLV, 1'b1}, 32'(i2c_slave_model_i.wlog[0]));
    chk("irqs", 32'(t0 + 5), 32'(n_txe));
    chk("acks", 32'h3, 32'(i2c_slave_model_i.mlog.size()));
    for (int k = 0; k < 3; k++) begin
      chk("ack", 32'(k == 2), 32'(i2c_slave_model_i.mlog[k]));
      chk("rx", 32'(8'hc3 ^ 8'(k)), 32'(rxq[k]));
    end
  endtask

  task automatic t_wr_rd;
    int s0, r0, t0;
    s0 = i2c_slave_model_i.stops;
    r0 = i2c_slave_model_i.restarts;
    t0 = n_txe;
    i2c_slave_model_i.wlog.delete();
    i2c_slave_model_i.mlog.delete();
    rxq.delete();
    wq = '{8'h10, 8'h9e};
    stretch_en = 1;
    launch(1'b1, 2'd2, SLV, 8'h02, 8'h02);
    wait_end(4000);
    stretch_en = 0;
    chk("wlog n", 32'h4, 32'(i2c_slave_model_i.wlog.size()));
    chk("addr w", {25'h0, SLV, 1'b0}, 32'(i2c_slave_model_i.wlog[0]));
    chk("data0", 32'h10, 32'(i2c_slave_model_i.wlog[1]));
    chk("data1", 32'h9e, 32'(i2c_slave_model_i.wlog[2]));
    chk("addr r", {25'h0, SLV, 1'b1}, 32'(i2c_slave_model_i.wlog[3]));
    chk("restart", 32'(r0 + 1), 32'(i2c_slave_model_i.restarts));
    chk("stops", 32'(s0 + 1), 32'(i2c_slave_model_i.stops));
    chk("irqs", 32'(t0 + 8), 32'(n_txe));
    chk("ack", 32'h0, 32'(i2c_slave_model_i.mlog[0]));
    chk("nack", 32'h1, 32'(i2c_slave_model_i.mlog[1]));
    chk("rx1", 32'hc2, 32'(rxq[1]));
    chk("flag2", 32'(state_transfer_done), 32'(flags[2]));
    chk("flag1", 32'(state_transfer_done), 32'(flags[1]));
  endtask

  task automatic t_nack;
    int s0;
    s0 = i2c_slave_model_i.stops;
    launch(1'b0, 2'd3, 7'h21, 8'h00, 8'h02);
    wait_end(2000);
    chk("stops", 32'(s0 + 1), 32'(i2c_slave_model_i.stops));
    chk("flag3", 32'(state_not_acknowledged), 32'(flags[3]));
  endtask

  task automatic t_fill;
    int s0, k;
    s0 = i2c_slave_model_i.sent;
    rxq.delete();
    sink_en = 0;
    launch(1'b0, 2'd0, SLV, 8'h00, 8'd40);
    for (k = 0; k < 5000 && i2c_slave_model_i.sent - s0 < 33; k++)
      @(posedge clk);
    repeat (300) @(posedge clk);
    @(negedge clk);
    chk("stalled", 32'(s0 + 33), 32'(i2c_slave_model_i.sent));
    chk("scl held", 32'h1, 32'(scl_oe));
    sink_en = 1;
    wait_end(6000);
    chk("rx n", 32'd40, 32'(rxq.size()));
    for (k = 0; k < 40; k++) chk("rx", 32'(8'hc3 ^ 8'(k)), 32'(rxq[k]));
  endtask

  task automatic t_err;
    int t0, k;
    t0 = n_txe;
    launch(1'b0, 2'd1, SLV, 8'h00, 8'h02);
    for (k = 0; k < 500 && n_txe == t0; k++) @(posedge clk);
    @(negedge clk);
    jam = 1;
    for (k = 0; k < 500 && flags[1] !== flag_error; k++) @(posedge clk);
    @(negedge clk);
    jam = 0;
    repeat (20) @(negedge clk);
    chk("flag1", 32'(flag_error), 32'(flags[1]));
    chk("ctl", 32'(ctl_comm), 32'(ctl_state));
    chk("sda oe", 32'h0, 32'(sda_oe));
    launch(1'b0, 2'd2, SLV, 8'h00, 8'h01);
    chk("flag2", 32'(state_transfer_done), 32'(flags[2]));
    chan_reset = 1;
    @(negedge clk);
    chan_reset = 0;
    @(negedge clk);
    chk("ctl", 32'(ctl_uninit), 32'(ctl_state));
    chk("flag1", 32'(flag_no_init), 32'(flags[1]));
  endtask

  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_n = 1;
    t_reset();
    t_read();
    t_wr_rd();
    t_nack();
    t_fill();
    t_err();
    close_out();
  end
endmodule
